// ===== btv_regs.svh
// Register offsets, field positions, reset values and counts of the backup trip voter.
// Assumes a 10 MHz aclk and 16-bit conditioned level and pressure words.
`ifndef BTV_REGS_SVH
`define BTV_REGS_SVH
`define BTV_OFF_CTRL 8'h00
`define BTV_OFF_LOWSP 8'h04
`define BTV_OFF_PERMSP 8'h08
`define BTV_OFF_ACTDLY 8'h0C
`define BTV_OFF_PERMDLY 8'h10
`define BTV_OFF_STAT 8'h14
`define BTV_OFF_SELF 8'h18
`define BTV_CTRL_MAINT 0
`define BTV_CTRL_TEST 1
`define BTV_CTRL_CAL 2
`define BTV_CTRL_OOS_LO 4
`define BTV_SELF_XFAULT 3
`define BTV_SELF_VFAIL 4
`define BTV_RST_LOWSP 16'h4000
`define BTV_RST_PERMSP 16'h6666
`define BTV_RST_ACTDLY 16'h0100
`define BTV_RST_PERMDLY 16'h0200
`define BTV_CAL_CYC 16'h0040
`define BTV_RESP_OKAY 2'h0
`define BTV_RESP_SLVERR 2'h2
`endif

// ===== btv_pkg.sv
// Types shared by the backup trip voter modules.
// Assumes btv_regs.svh supplies the numeric constants.
package btv_pkg;
    typedef logic [15:0] btv_word_t;
    typedef btv_word_t [2:0] btv_levels_t;
    typedef btv_word_t [1:0] btv_press_t;
    typedef struct packed {
        logic bd_iso;
        logic turb_trip;
        logic efw;
    } btv_relay_t;
    typedef struct packed {
        btv_word_t low_sp;
        btv_word_t perm_sp;
        btv_word_t act_dly;
        btv_word_t perm_dly;
    } btv_cfg_t;
    typedef enum logic [2:0] {
        BTV_BLOCKED = 3'b001,
        BTV_ARMED = 3'b010,
        BTV_HOLDOFF = 3'b100
    } btv_perm_e;
    typedef struct packed {
        btv_word_t cnt;
        logic dem;
    } btv_chan_st_t;
    typedef struct packed {
        btv_relay_t relay;
        logic vote;
    } btv_vote_st_t;
    typedef struct packed {
        logic aw_ok;
        logic [7:0] awaddr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        btv_cfg_t cfg;
        logic maint;
        logic test;
        logic vtest;
        logic [2:0] oos;
        btv_word_t cal_cnt;
        btv_perm_e perm;
        btv_word_t pcnt;
        logic [2:0] vt;
        logic vfail;
        logic [2:0] cfault;
        logic xfault;
        btv_word_t plant;
    } btv_top_st_t;

    // Two-of-three majority, used by channels, voters and the self-check
    function automatic logic btv_maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : btv_maj3
endpackage : btv_pkg

// ===== btv_channel.sv
// One logic channel: low-level coincidence gated by the permissive, then actuation delay.
// Assumes levels and setpoints are unsigned words synchronous to aclk.
`timescale 1ns/10ps
`include "btv_regs.svh"
module btv_channel
    import btv_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire btv_levels_t levels,
    input wire btv_word_t low_sp,
    input wire btv_word_t act_dly,
    input wire logic armed,
    input wire logic in_service,
    output logic demand
);
    btv_chan_st_t st_q, st_d;
    logic [2:0] low;
    logic cond;

    // Per-generator low comparisons and 2oo3 coincidence with the permissive
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            low[i] = levels[i] < low_sp;
        end
        cond = btv_maj3(low) & armed & in_service;
    end

    // Delay counter restarts whenever the condition drops, so brief dips never trip
    always_comb begin
        st_d = st_q;
        if (!cond) begin
            st_d.cnt = 16'h0000;
            st_d.dem = 1'b0;
        end else if (st_q.cnt >= act_dly) begin
            st_d.dem = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign demand = st_q.dem;

    property p_dem_cause;
        @(posedge aclk) disable iff (!aresetn) st_q.dem |-> $past(cond);
    endproperty
    a_dem_cause: assert property (p_dem_cause) else $error("demand without trip condition");

    property p_dem_delay;
        @(posedge aclk) disable iff (!aresetn)
            $rose(st_q.dem) |-> ($past(st_q.cnt) == $past(act_dly)) && $past(cond);
    endproperty
    a_dem_delay: assert property (p_dem_delay) else $error("demand before delay ran out");
endmodule : btv_channel

// ===== btv_voter.sv
// One majority voting module feeding one relay panel with three actions.
// Assumes demands are registered channel outputs in the aclk domain.
`timescale 1ns/10ps
`include "btv_regs.svh"
module btv_voter
    import btv_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] dem,
    input wire logic block,
    output logic vote,
    output btv_relay_t relay
);
    btv_vote_st_t st_q, st_d;

    // Raw vote kept for self-check; relays also gated by bypass
    always_comb begin
        st_d.vote = btv_maj3(dem);
        st_d.relay.efw = st_d.vote & ~block;
        st_d.relay.turb_trip = st_d.vote & ~block;
        st_d.relay.bd_iso = st_d.vote & ~block;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign vote = st_q.vote;
    assign relay = st_q.relay;

    property p_two_of_three;
        @(posedge aclk) disable iff (!aresetn)
            $past(aresetn) && st_q.relay.efw |-> $countones($past(dem)) >= 2 && !$past(block);
    endproperty
    a_two_of_three: assert property (p_two_of_three) else $error("relay without two demands");

    property p_all_actions;
        @(posedge aclk) disable iff (!aresetn)
            st_q.relay.turb_trip == st_q.relay.efw && st_q.relay.bd_iso == st_q.relay.efw;
    endproperty
    a_all_actions: assert property (p_all_actions) else $error("relay actions disagree");
endmodule : btv_voter

// ===== btv_top.sv
// Backup trip actuation logic: permissive, three channels, two voters, AXI4-Lite registers.
// Assumes one 10 MHz aclk, synchronous active-low reset, inputs synchronous to aclk.
`timescale 1ns/10ps
`include "btv_regs.svh"
module btv_top
    import btv_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire btv_levels_t sg_level,
    input wire btv_press_t impulse_press,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output btv_relay_t relay_a,
    output btv_relay_t relay_b,
    output logic armed_ind,
    output logic bypass_ind,
    output btv_word_t plant_status
);
    localparam btv_top_st_t RST = '{
        cfg: '{low_sp: `BTV_RST_LOWSP, perm_sp: `BTV_RST_PERMSP,
               act_dly: `BTV_RST_ACTDLY, perm_dly: `BTV_RST_PERMDLY},
        perm: BTV_BLOCKED,
        default: '0
    };

    btv_top_st_t st_q, st_d;
    logic above, armed, bypass;
    logic [2:0] dem, vin;
    logic vote_a, vote_b;
    btv_word_t stat_w;

    // Byte-lane merge of a 16-bit register with a write
    function automatic btv_word_t merge16(input btv_word_t old, input logic [31:0] d,
                                          input logic [3:0] s);
        btv_word_t r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : merge16

    // Both pressures must exceed the setpoint, so one failed-high transmitter cannot arm
    assign above = (impulse_press[0] > st_q.cfg.perm_sp) &&
                   (impulse_press[1] > st_q.cfg.perm_sp);
    assign armed = st_q.perm != BTV_BLOCKED;
    // Maintenance, test and calibration all block at system level
    assign bypass = st_q.maint | st_q.test | (st_q.cal_cnt != 16'h0000);
    // During test the voters see the walking pattern instead of live demands
    assign vin = st_q.test ? st_q.vt : dem;

    // Three identical channels on the same levels and setpoints, each with its own out-of-service bit
    generate
        for (genvar g = 0; g < 3; g++) begin : g_chan
            btv_channel u_chan (
                .aclk(aclk),
                .aresetn(aresetn),
                .levels(sg_level),
                .low_sp(st_q.cfg.low_sp),
                .act_dly(st_q.cfg.act_dly),
                .armed(armed),
                .in_service(~st_q.oos[g]),
                .demand(dem[g])
            );
        end
    endgenerate

    // Two voting modules, one per relay panel
    btv_voter u_vote_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .dem(vin),
        .block(bypass),
        .vote(vote_a),
        .relay(relay_a)
    );
    btv_voter u_vote_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .dem(vin),
        .block(bypass),
        .vote(vote_b),
        .relay(relay_b)
    );

    // Status word shown to software, the plant computer and the board
    always_comb begin
        stat_w = 16'h0000;
        stat_w[0] = armed;
        stat_w[1] = bypass;
        stat_w[4:2] = dem;
        stat_w[5] = relay_a.efw;
        stat_w[6] = relay_b.efw;
        stat_w[7] = st_q.cal_cnt != 16'h0000;
        stat_w[10:8] = st_q.cfault;
        stat_w[11] = st_q.xfault;
        stat_w[12] = st_q.vfail;
    end

    // Next-state logic: bus slave, control, permissive and self-check
    always_comb begin
        st_d = st_q;
        st_d.plant = stat_w;
        st_d.vtest = st_q.test;
        st_d.vt = st_q.vt + 3'h1;
        if (st_q.cal_cnt != 16'h0000) begin
            st_d.cal_cnt = st_q.cal_cnt - 16'h0001;
        end

        // Permissive with off-delay; pressure back above restarts the count
        case (st_q.perm)
            BTV_BLOCKED: begin
                if (above) begin
                    st_d.perm = BTV_ARMED;
                end
            end
            BTV_ARMED: begin
                if (!above) begin
                    st_d.perm = BTV_HOLDOFF;
                    st_d.pcnt = 16'h0000;
                end
            end
            BTV_HOLDOFF: begin
                if (above) begin
                    st_d.perm = BTV_ARMED;
                end else if (st_q.pcnt >= st_q.cfg.perm_dly) begin
                    st_d.perm = BTV_BLOCKED;
                end else begin
                    st_d.pcnt = st_q.pcnt + 16'h0001;
                end
            end
            default: begin
                st_d.perm = BTV_BLOCKED;
            end
        endcase

        // Write channel: address and data latched in either order
        if (bvalid && bready) begin
            st_d.bvalid = 1'b0;
        end
        if (awvalid && awready) begin
            st_d.aw_ok = 1'b1;
            st_d.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            st_d.w_ok = 1'b1;
            st_d.wdata = wdata;
            st_d.wstrb = wstrb;
        end
        if (st_q.aw_ok && st_q.w_ok) begin
            st_d.aw_ok = 1'b0;
            st_d.w_ok = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = `BTV_RESP_OKAY;
            case (st_q.awaddr)
                `BTV_OFF_CTRL: begin
                    if (st_q.wstrb[0]) begin
                        st_d.maint = st_q.wdata[`BTV_CTRL_MAINT];
                        st_d.test = st_q.wdata[`BTV_CTRL_TEST];
                        if (st_q.maint) begin
                            st_d.oos = st_q.wdata[`BTV_CTRL_OOS_LO +: 3];
                            if (st_q.wdata[`BTV_CTRL_CAL]) begin
                                st_d.cal_cnt = `BTV_CAL_CYC;
                            end
                        end
                    end
                end
                `BTV_OFF_LOWSP: begin
                    if (st_q.maint) begin
                        st_d.cfg.low_sp = merge16(st_q.cfg.low_sp, st_q.wdata,
                                                  st_q.wstrb);
                    end
                end
                `BTV_OFF_PERMSP: begin
                    if (st_q.maint) begin
                        st_d.cfg.perm_sp = merge16(st_q.cfg.perm_sp, st_q.wdata,
                                                   st_q.wstrb);
                    end
                end
                `BTV_OFF_ACTDLY: begin
                    if (st_q.maint) begin
                        st_d.cfg.act_dly = merge16(st_q.cfg.act_dly, st_q.wdata,
                                                   st_q.wstrb);
                    end
                end
                `BTV_OFF_PERMDLY: begin
                    if (st_q.maint) begin
                        st_d.cfg.perm_dly = merge16(st_q.cfg.perm_dly, st_q.wdata,
                                                    st_q.wstrb);
                    end
                end
                `BTV_OFF_SELF: begin
                    if (st_q.wstrb[0]) begin
                        st_d.cfault = st_q.cfault & ~st_q.wdata[2:0];
                        st_d.xfault = st_q.xfault & ~st_q.wdata[`BTV_SELF_XFAULT];
                        st_d.vfail = st_q.vfail & ~st_q.wdata[`BTV_SELF_VFAIL];
                    end
                end
                `BTV_OFF_STAT: begin
                    st_d.bresp = `BTV_RESP_OKAY;
                end
                default: begin
                    st_d.bresp = `BTV_RESP_SLVERR;
                end
            endcase
        end

        // Self-check sets after the clear so a fault in the clear cycle survives
        for (int i = 0; i < 3; i++) begin
            if (!st_q.test && !st_q.oos[i] && dem[i] != btv_maj3(dem)) begin
                st_d.cfault[i] = 1'b1;
            end
        end
        if (vote_a != vote_b) begin
            st_d.xfault = 1'b1;
        end
        if (st_q.vtest && st_q.test &&
            (vote_a != btv_maj3(st_q.vt - 3'h1) || vote_b != btv_maj3(st_q.vt - 3'h1))) begin
            st_d.vfail = 1'b1;
        end

        // Read channel: answer one cycle after the address is taken
        if (rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = `BTV_RESP_OKAY;
            st_d.rdata = 32'h0000_0000;
            case (araddr)
                `BTV_OFF_CTRL: begin
                    st_d.rdata[`BTV_CTRL_MAINT] = st_q.maint;
                    st_d.rdata[`BTV_CTRL_TEST] = st_q.test;
                    st_d.rdata[`BTV_CTRL_OOS_LO +: 3] = st_q.oos;
                end
                `BTV_OFF_LOWSP: begin
                    st_d.rdata[15:0] = st_q.cfg.low_sp;
                end
                `BTV_OFF_PERMSP: begin
                    st_d.rdata[15:0] = st_q.cfg.perm_sp;
                end
                `BTV_OFF_ACTDLY: begin
                    st_d.rdata[15:0] = st_q.cfg.act_dly;
                end
                `BTV_OFF_PERMDLY: begin
                    st_d.rdata[15:0] = st_q.cfg.perm_dly;
                end
                `BTV_OFF_STAT: begin
                    st_d.rdata[15:0] = stat_w;
                end
                `BTV_OFF_SELF: begin
                    st_d.rdata[2:0] = st_q.cfault;
                    st_d.rdata[`BTV_SELF_XFAULT] = st_q.xfault;
                    st_d.rdata[`BTV_SELF_VFAIL] = st_q.vfail;
                end
                default: begin
                    st_d.rresp = `BTV_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Handshakes come straight from state; one write and one read in flight
    assign awready = !st_q.aw_ok && !st_q.bvalid;
    assign wready = !st_q.w_ok && !st_q.bvalid;
    assign bvalid = st_q.bvalid;
    assign bresp = st_q.bresp;
    assign arready = !st_q.rvalid;
    assign rvalid = st_q.rvalid;
    assign rdata = st_q.rdata;
    assign rresp = st_q.rresp;
    assign armed_ind = armed;
    assign bypass_ind = bypass;
    assign plant_status = st_q.plant;

    property p_arm_cause;
        @(posedge aclk) disable iff (!aresetn)
            $past(aresetn) && $rose(armed) |-> $past(above);
    endproperty
    a_arm_cause: assert property (p_arm_cause) else $error("armed without both pressures");

    property p_offdelay;
        @(posedge aclk) disable iff (!aresetn)
            $past(aresetn) && $fell(armed) |->
                $past(st_q.pcnt) == $past(st_q.cfg.perm_dly) && !$past(above);
    endproperty
    a_offdelay: assert property (p_offdelay) else $error("permissive dropped early");

    property p_locked;
        @(posedge aclk) disable iff (!aresetn)
            !st_q.maint |=> $stable(st_q.cfg);
    endproperty
    a_locked: assert property (p_locked) else $error("setpoint changed outside maintenance");

    property p_bypass_blocks;
        @(posedge aclk) disable iff (!aresetn)
            bypass |=> relay_a == 3'h0 && relay_b == 3'h0;
    endproperty
    a_bypass_blocks: assert property (p_bypass_blocks) else $error("relay during bypass");

    property p_needs_armed;
        @(posedge aclk) disable iff (!aresetn)
            $past(aresetn, 3) && relay_a.efw && !$past(st_q.test) |-> $past(armed, 2);
    endproperty
    a_needs_armed: assert property (p_needs_armed) else $error("relay while blocked");
endmodule : btv_top

// ===== btv_relay_panel.sv
// Relay panel model standing behind one voter output.
// Assumes relay bits are registered in the aclk domain.
`timescale 1ns/10ps
module btv_relay_panel
    import btv_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire btv_relay_t relay,
    output logic energised,
    output logic [7:0] act_cnt
);
    logic prev_q;
    logic [7:0] cnt_q;
    // A panel acts only when all three circuits are driven together
    assign energised = relay.efw & relay.turb_trip & relay.bd_iso;
    assign act_cnt = cnt_q;
    // One count per actuation, so a chattering relay shows up as extra counts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            prev_q <= energised;
            if (energised & ~prev_q) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule : btv_relay_panel

// ===== testbench.sv
// Self-checking bench for the backup trip voter top and its two relay panels.
// Assumes btv_pkg and the relay panel model are compiled first.
`timescale 1ns/10ps
`include "btv_regs.svh"
module testbench
    import btv_pkg::*;
;
    localparam int ACT_DLY = 2;
    localparam int PERM_DLY = 4;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, armed_ind, bypass_ind, en_a, en_b;
    logic [7:0] awaddr, araddr, cnt_a, cnt_b;
    logic [31:0] wdata, rdata, rd, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [2:0] low_m;
    btv_levels_t sg_level;
    btv_press_t impulse_press;
    btv_relay_t relay_a, relay_b;
    btv_word_t plant_status;
    btv_word_t rst_v [4] = '{`BTV_RST_LOWSP, `BTV_RST_PERMSP, `BTV_RST_ACTDLY, `BTV_RST_PERMDLY};
    int bad_count, total_checks;

    btv_top i_dut (.aclk(aclk), .aresetn(aresetn), .sg_level(sg_level),
        .impulse_press(impulse_press), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .relay_a(relay_a),
        .relay_b(relay_b), .armed_ind(armed_ind), .bypass_ind(bypass_ind),
        .plant_status(plant_status));
    btv_relay_panel i_panel_a (.aclk(aclk), .aresetn(aresetn), .relay(relay_a),
        .energised(en_a), .act_cnt(cnt_a));
    btv_relay_panel i_panel_b (.aclk(aclk), .aresetn(aresetn), .relay(relay_b),
        .energised(en_b), .act_cnt(cnt_b));

    // Free-running 10 MHz clock
    always #50 aclk = ~aclk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Two of three low levels while armed drive all three actions
    function automatic logic [31:0] exp_rel(input logic [2:0] m, input logic arm);
        return (((m[0] & m[1]) | (m[0] & m[2]) | (m[1] & m[2])) & arm) ? 32'h7 : 32'h0;
    endfunction : exp_rel

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // Land in the n-th cycle after the last drive, away from the edge
    task at_cyc(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : at_cyc

    // Random levels and pressures, below or above the setpoints as the masks ask
    task set_in(input logic [2:0] lm, input logic [1:0] hp);
        @(posedge aclk);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr_next(seed);
            sg_level[i] <= lm[i] ? {2'h0, seed[13:0]} : {1'h1, seed[14:0]};
        end
        for (int i = 0; i < 2; i++) begin
            seed = lfsr_next(seed);
            impulse_press[i] <= hp[i] ? {1'h1, seed[14:0]} : {2'h0, seed[13:0]};
        end
    endtask : set_in

    // Address and data offered together, each dropped once taken
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        r = bresp;
        bready <= 1'b0;
        if (n >= 100) bad_count++;
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) bad_count++;
    endtask : axi_rd

    // Watchdog sized well above the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        stop_test();
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        seed = 32'h00017D81;
        sg_level = '1;
        impulse_press = '0;
        bad_count = 0;
        total_checks = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            axi_rd(8'h04 + 8'(4 * i), rd, rsp);
            chk(rd, {16'h0, rst_v[i]});
        end
        axi_rd(8'h40, rd, rsp);
        chk({30'h0, rsp}, {30'h0, `BTV_RESP_SLVERR});
        axi_wr(8'h40, 32'h0, rsp);
        chk({30'h0, rsp}, {30'h0, `BTV_RESP_SLVERR});
        axi_wr(`BTV_OFF_LOWSP, 32'h1234, rsp);
        chk({30'h0, rsp}, {30'h0, `BTV_RESP_OKAY});
        axi_rd(`BTV_OFF_LOWSP, rd, rsp);
        chk(rd, {16'h0, `BTV_RST_LOWSP});
        // Shorten both timers under maintenance, then leave it
        axi_wr(`BTV_OFF_CTRL, 32'h1, rsp);
        at_cyc(1);
        chk({31'h0, bypass_ind}, 32'h1);
        // Calibration start shows busy and bypass, then runs out on its own
        axi_wr(`BTV_OFF_CTRL, 32'h5, rsp);
        axi_rd(`BTV_OFF_STAT, rd, rsp);
        chk(rd & 32'h82, 32'h82);
        at_cyc(`BTV_CAL_CYC);
        axi_rd(`BTV_OFF_STAT, rd, rsp);
        chk(rd & 32'h80, 32'h0);
        axi_wr(`BTV_OFF_ACTDLY, ACT_DLY, rsp);
        axi_wr(`BTV_OFF_PERMDLY, PERM_DLY, rsp);
        axi_wr(`BTV_OFF_CTRL, 32'h10, rsp); // Channel 0 stays out of service from here on
        axi_wr(`BTV_OFF_ACTDLY, 32'h55, rsp);
        axi_rd(`BTV_OFF_ACTDLY, rd, rsp);
        chk(rd, ACT_DLY);
        axi_rd(`BTV_OFF_CTRL, rd, rsp);
        chk(rd, 32'h10);
        set_in(3'b000, 2'b01);
        at_cyc(3);
        chk({31'h0, armed_ind}, 32'h0);
        set_in(3'b000, 2'b11);
        at_cyc(1);
        chk({31'h0, armed_ind}, 32'h1);
        axi_rd(`BTV_OFF_STAT, rd, rsp);
        chk(rd & 32'h1, 32'h1);
        chk({31'h0, plant_status[0]}, 32'h1);
        // Each pair of low levels trips; a lone low level does not
        for (int k = 0; k < 4; k++) begin
            low_m = (k == 3) ? 3'b100 : ~(3'b001 << k);
            set_in(3'b000, 2'b11);
            at_cyc(ACT_DLY + 4);
            set_in(low_m, 2'b11);
            at_cyc(ACT_DLY + 1);
            chk({29'h0, relay_a}, 32'h0);
            at_cyc(1);
            chk({29'h0, relay_a}, exp_rel(low_m, 1'b1));
            chk({29'h0, relay_b}, exp_rel(low_m, 1'b1));
            chk({30'h0, en_a, en_b}, (exp_rel(low_m, 1'b1) != 0) ? 32'h3 : 32'h0);
        end
        chk({16'h0, cnt_a, cnt_b}, 32'h0303);
        // A one-cycle gap in the condition restarts the delay
        set_in(3'b000, 2'b11);
        at_cyc(ACT_DLY + 4);
        set_in(3'b011, 2'b11);
        set_in(3'b000, 2'b11);
        set_in(3'b011, 2'b11);
        at_cyc(ACT_DLY + 1);
        chk({29'h0, relay_a}, 32'h0);
        at_cyc(1);
        chk({29'h0, relay_b}, 32'h7);
        // Out-of-service channel shows no demand, the other two still vote, no fault flagged
        axi_rd(`BTV_OFF_STAT, rd, rsp);
        chk(rd & 32'h1FFF, 32'h79);
        // Test mode drops the relays and runs the voter walk without faults
        axi_wr(`BTV_OFF_CTRL, 32'h2, rsp);
        at_cyc(1);
        chk({30'h0, bypass_ind, relay_a.efw}, 32'h2);
        at_cyc(10);
        axi_rd(`BTV_OFF_SELF, rd, rsp);
        chk(rd & 32'h18, 32'h0);
        axi_wr(`BTV_OFF_CTRL, 32'h0, rsp);
        // Pressure drop holds the permissive for the off-delay only
        set_in(3'b000, 2'b11);
        at_cyc(ACT_DLY + 4);
        set_in(3'b000, 2'b00);
        at_cyc(PERM_DLY + 1);
        chk({31'h0, armed_ind}, 32'h1);
        at_cyc(1);
        chk({31'h0, armed_ind}, 32'h0);
        set_in(3'b011, 2'b00);
        at_cyc(ACT_DLY + 4);
        chk({29'h0, relay_a}, 32'h0);
        stop_test();
    end
endmodule : testbench
